// [dv/ims_status_tb.sv]
// Self-checking bench for the masked interrupt status block.
// Assumes an AXI4-Lite slave with live FIFO levels and pulse event inputs.
`timescale 1ns/1ps
module ims_status_tb;
  import ims_pkg::*;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, act = 0, stop = 0;
  logic awready, wready, bvalid, arready, rvalid, stretch, irq;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [1:0] bresp, rresp;
  logic [4:0] txc = 0, rxc = 0, tthr = 0, rthr = 0;
  logic [7:0] ev = 0;
  logic [15:0] r = 16'h37b0;
  logic [33:0] rq[$], bq[$];
  int n_mismatch = 0, total_checks = 0;

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  ims_status u_ims_status (.core_clk_in(clk), .reset_in(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_count_in(txc),
    .rx_count_in(rxc), .tx_push_in(ev[0]), .slave_read_req_in(ev[1]),
    .slave_read_active_in(act), .slave_write_req_in(ev[2]),
    .slave_req_served_in(ev[3]), .master_done_in(ev[4]),
    .master_stop_in(stop), .slave_done_in(ev[5]), .arb_lost_in(ev[6]),
    .bus_error_in(ev[7]), .scl_stretch_out(stretch), .irq_out(irq));

  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Level bits expected from the counts, thresholds and activity now driven.
  function automatic logic [31:0] lev();
    logic [31:0] e;
    e = '0;
    e[IMS_TXE] = (txc == 0);
    e[IMS_TXNE] = (txc <= tthr);
    e[IMS_TXF] = (txc == 5'd16);
    e[IMS_RXE] = (rxc == 0);
    e[IMS_RXNF] = (rxc >= rthr);
    e[IMS_RXF] = (rxc == 5'd16);
    e[IMS_SRDUND] = act && (txc == 0);
    return e;
  endfunction

  task automatic end_of_test();
    // A note still waiting at the end is a response that never came.
    if (rq.size() != 0 || bq.size() != 0) n_mismatch++;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    n_mismatch++;
    end_of_test();
  endtask

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = IMS_OKAY);
    int n;
    bq.push_back({32'h0, e});
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    if (n == 40) tmo();
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = IMS_OKAY);
    int n;
    rq.push_back({e, d});
    araddr <= {24'h0, a};
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    if (n == 40) tmo();
    @(posedge clk);
  endtask

  task automatic pulse(input logic [7:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 0;
    @(posedge clk);
  endtask

  // Responses are matched against the oldest note; a stray one has none.
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1)
      chk({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1)
      chk({32'h0, bresp}, bq.pop_front());
  end

  // Guards against a hung handshake that escapes the bounded loops.
  initial begin
    repeat (20000) @(posedge clk);
    tmo();
  end

  // Main sequence: levels, boundaries, sticky events, mask, bus errors.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(IMS_MASKED_OFS, 32'h0);
    chk(irq, 1'b0);
    rd(IMS_RAW_OFS, lev());
    wr(IMS_MASK_OFS, 32'hffffffff);
    repeat (8) begin
      r = lf(r);
      txc <= r[4:0] % 17;
      rxc <= r[9:5] % 17;
      act <= r[13];
      tthr = {2'h0, r[12:10]} * 2;
      rthr = {1'b0, r[15:12]};
      wr(IMS_TX_THR_OFS, {27'h0, tthr});
      wr(IMS_RX_THR_OFS, {27'h0, rthr});
      rd(IMS_TX_THR_OFS, {27'h0, tthr});
      rd(IMS_RX_THR_OFS, {27'h0, rthr});
      rd(IMS_MASKED_OFS, lev());
      chk(irq, |lev());
    end
    txc <= 5'd0;
    rxc <= 5'd16;
    act <= 1;
    @(posedge clk);
    rd(IMS_MASKED_OFS, lev());
    txc <= 5'd16;
    act <= 0;
    @(posedge clk);
    rd(IMS_MASKED_OFS, lev());
    pulse(8'hf1);
    rd(IMS_MASKED_OFS, lev() | 32'h13180008);
    chk(stretch, 1'b1);
    rd(IMS_CTRL_OFS, 32'h1);
    rd(IMS_CLEAR_OFS, 32'h0);
    pulse(8'h06);
    rd(IMS_MASKED_OFS, lev() | 32'h13180008);
    wr(IMS_CLEAR_OFS, 32'h0);
    rd(IMS_MASKED_OFS, lev() | 32'h13180008);
    wr(IMS_CLEAR_OFS, 32'h13180008);
    rd(IMS_MASKED_OFS, lev() | 32'h00050000);
    chk(stretch, 1'b0);
    rd(IMS_CTRL_OFS, 32'h0);
    pulse(8'h08);
    rd(IMS_MASKED_OFS, lev());
    stop <= 1;
    pulse(8'h10);
    rd(IMS_MASKED_OFS, lev() | 32'h00080000);
    wr(IMS_MASK_OFS, 32'h00080000);
    rd(IMS_MASKED_OFS, 32'h00080000);
    chk(irq, 1'b1);
    wr(IMS_MASK_OFS, 32'h0);
    wr(IMS_MASKED_OFS, 32'hffffffff);
    rd(IMS_MASKED_OFS, 32'h0);
    chk(irq, 1'b0);
    rd(IMS_RAW_OFS, lev() | 32'h00080000);
    wr(8'h50, 32'h1, IMS_SLVERR);
    rd(8'h50, 32'h0, IMS_SLVERR);
    end_of_test();
  end
endmodule

// [hw/ims_status.sv]
// Masked interrupt status word of a two-wire controller with its register
// file: raw status, mask, clear, thresholds and a clock-stretch output.
// Assumes FIFO levels and transfer-engine events arrive synchronous to clk.
`timescale 1ns/1ps
module ims_status
  import ims_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic core_clk_in, // 50 MHz clock.
  input wire logic reset_in, // Asynchronous reset, active high.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [CNT_W-1:0] tx_count_in, // Transmit FIFO entries.
  input wire logic [CNT_W-1:0] rx_count_in, // Receive FIFO entries.
  input wire logic tx_push_in, // Write into transmit FIFO, one cycle.
  input wire logic slave_read_req_in, // Slave read addressed, pulse.
  input wire logic slave_read_active_in, // Slave read in progress, level.
  input wire logic slave_write_req_in, // Slave write addressed, pulse.
  input wire logic slave_req_served_in, // Slave request served, pulse.
  input wire logic master_done_in, // Master transfer finished, pulse.
  input wire logic master_stop_in, // That transfer ended with stop.
  input wire logic slave_done_in, // Slave transfer finished, pulse.
  input wire logic arb_lost_in, // Arbitration lost, pulse.
  input wire logic bus_error_in, // Bus error detected, pulse.
  output logic scl_stretch_out, // Hold serial clock low.
  output logic irq_out // Level interrupt, high if any masked bit.
);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);

  // Count width must hold the full depth, or the full compare matches a truncated count.
  if (FIFO_DEPTH < 2 || FIFO_DEPTH >= (1 << CNT_W)) begin : g_bad_depth
    $error("ims_status: FIFO_DEPTH does not fit CNT_W");
  end

  typedef struct packed {
    logic [31:0] sticky;
    logic [31:0] mask;
    logic [CNT_W-1:0] tx_thr;
    logic [CNT_W-1:0] rx_thr;
    logic srd_pend;
    logic swr_pend;
    ims_wst_t wst;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ims_state_t;

  ims_state_t s_q;
  ims_state_t s_d;
  logic [31:0] raw;
  logic [31:0] masked;
  logic done_hold;
  logic wr_go;
  logic rd_go;
  logic [31:0] wr_clr;
  logic [31:0] set_ev;
  logic [7:0] waddr;
  logic [7:0] raddr;

  // A pending acknowledgment keeps the clock low and holds back new
  // slave requests, so software never sees two transactions merged.
  assign done_hold = s_q.sticky[IMS_MDONE] | s_q.sticky[IMS_SDONE] |
                     s_q.sticky[IMS_MDNS];
  assign scl_stretch_out = done_hold;

  // Raw status word: FIFO levels and the slave read underrun are live, slave requests come from pending flags, other events from sticky bits.
  always_comb begin
    raw = s_q.sticky & IMS_STICKY;
    raw[IMS_TXE] = (tx_count_in == '0);
    raw[IMS_TXNE] = (tx_count_in <= s_q.tx_thr);
    raw[IMS_TXF] = (tx_count_in == FULL_CNT);
    raw[IMS_RXE] = (rx_count_in == '0);
    raw[IMS_RXNF] = (rx_count_in >= s_q.rx_thr);
    raw[IMS_RXF] = (rx_count_in == FULL_CNT);
    raw[IMS_SRDREQ] = s_q.srd_pend & ~done_hold;
    raw[IMS_SRDUND] = slave_read_active_in & (tx_count_in == '0);
    raw[IMS_SWRREQ] = s_q.swr_pend & ~done_hold;
  end

  assign masked = raw & s_q.mask & IMS_IMPL;
  assign irq_out = |masked;

  // Both write channels are taken together in one cycle.
  assign waddr = s_axi_awaddr[7:0];
  assign raddr = s_axi_araddr[7:0];
  assign s_axi_awready = (s_q.wst == IMS_IDLE) & s_axi_wvalid;
  assign s_axi_wready = (s_q.wst == IMS_IDLE) & s_axi_awvalid;
  assign wr_go = s_axi_awready & s_axi_awvalid;
  assign s_axi_bvalid = (s_q.wst == IMS_RESP);
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign wr_clr = (wr_go && waddr == IMS_CLEAR_OFS) ?
                  (s_axi_wdata & IMS_STICKY) : 32'h00000000;

  // Event sources for the sticky bits.
  always_comb begin
    set_ev = 32'h00000000;
    set_ev[IMS_TXOVR] = tx_push_in & (tx_count_in == FULL_CNT);
    set_ev[IMS_MDONE] = master_done_in;
    set_ev[IMS_SDONE] = slave_done_in;
    set_ev[IMS_ARBL] = arb_lost_in;
    set_ev[IMS_BERR] = bus_error_in;
    set_ev[IMS_MDNS] = master_done_in & ~master_stop_in;
  end

  // Next-state logic for registers and both bus channels.
  always_comb begin
    s_d = s_q;
    // A new event in the clearing cycle wins over the clear.
    s_d.sticky = (s_q.sticky & ~wr_clr) | set_ev;
    s_d.srd_pend = (s_q.srd_pend & ~slave_req_served_in) |
                   slave_read_req_in;
    s_d.swr_pend = (s_q.swr_pend & ~slave_req_served_in) |
                   slave_write_req_in;
    if (wr_go) begin
      s_d.wst = IMS_RESP;
      s_d.bresp = IMS_OKAY;
      unique case (waddr)
        IMS_MASK_OFS: s_d.mask = s_axi_wdata & IMS_IMPL;
        IMS_TX_THR_OFS: s_d.tx_thr = s_axi_wdata[CNT_W-1:0];
        IMS_RX_THR_OFS: s_d.rx_thr = s_axi_wdata[CNT_W-1:0];
        IMS_MASKED_OFS, IMS_RAW_OFS, IMS_CLEAR_OFS: ;
        default: s_d.bresp = IMS_SLVERR;
      endcase
    end else if (s_q.wst == IMS_RESP && s_axi_bready) begin
      s_d.wst = IMS_IDLE;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = IMS_OKAY;
      unique case (raddr)
        IMS_MASKED_OFS: s_d.rdata = masked;
        IMS_RAW_OFS: s_d.rdata = raw & IMS_IMPL;
        IMS_CLEAR_OFS: s_d.rdata = 32'h00000000;
        IMS_MASK_OFS: s_d.rdata = s_q.mask;
        IMS_TX_THR_OFS: s_d.rdata = 32'(s_q.tx_thr);
        IMS_RX_THR_OFS: s_d.rdata = 32'(s_q.rx_thr);
        IMS_CTRL_OFS: s_d.rdata = 32'(done_hold);
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = IMS_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Overrun is set one edge after a push into a full FIFO.
  property p_overrun;
    @(posedge core_clk_in) disable iff (reset_in)
      tx_push_in && tx_count_in == FULL_CNT |=> s_q.sticky[IMS_TXOVR];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not latched");

  property p_irq;
    @(posedge core_clk_in) disable iff (reset_in)
      irq_out == |(raw & s_q.mask & IMS_IMPL);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq does not match masked bits");

  property p_stretch;
    @(posedge core_clk_in) disable iff (reset_in)
      master_done_in |=> scl_stretch_out;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock not stretched after done");

  sequence s_clear_mdone;
    wr_go && waddr == IMS_CLEAR_OFS && s_axi_wdata[IMS_MDONE] &&
      !master_done_in;
  endsequence
  property p_clear;
    @(posedge core_clk_in) disable iff (reset_in)
      s_clear_mdone |=> !s_q.sticky[IMS_MDONE];
  endproperty
  a_clear: assert property (p_clear)
    else $error("master done not cleared");

  property p_zero_noclear;
    @(posedge core_clk_in) disable iff (reset_in)
      wr_go && waddr == IMS_CLEAR_OFS && !s_axi_wdata[IMS_BERR] &&
        s_q.sticky[IMS_BERR] |=> s_q.sticky[IMS_BERR];
  endproperty
  a_zero_noclear: assert property (p_zero_noclear)
    else $error("zero write cleared bus error");

  // A masked read taken at this edge shows its data one edge later.
  sequence s_masked_rd;
    rd_go && raddr == IMS_MASKED_OFS;
  endsequence

  property p_rsvd;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd |=> (s_axi_rdata & ~IMS_IMPL) == 32'h00000000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits not zero");

  // A bit whose mask is clear never reaches the masked read data.
  property p_rd_unmasked;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd |=> (s_axi_rdata & ~$past(s_q.mask)) == 32'h00000000;
  endproperty
  a_rd_unmasked: assert property (p_rd_unmasked)
    else $error("masked-off bit read as set");

  // Each level bit except RXE, with its mask set, shows the level at the taking edge.
  property p_rd_txe;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd ##0 s_q.mask[IMS_TXE] |=>
        s_axi_rdata[IMS_TXE] == ($past(tx_count_in) == '0);
  endproperty
  a_rd_txe: assert property (p_rd_txe)
    else $error("tx empty bit wrong");

  property p_rd_txne;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd ##0 s_q.mask[IMS_TXNE] |=>
        s_axi_rdata[IMS_TXNE] == ($past(tx_count_in) <= $past(s_q.tx_thr));
  endproperty
  a_rd_txne: assert property (p_rd_txne)
    else $error("tx threshold bit wrong");

  property p_rd_txf;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd ##0 s_q.mask[IMS_TXF] |=>
        s_axi_rdata[IMS_TXF] == ($past(tx_count_in) == FULL_CNT);
  endproperty
  a_rd_txf: assert property (p_rd_txf)
    else $error("tx full bit wrong");

  property p_rd_rxnf;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd ##0 s_q.mask[IMS_RXNF] |=>
        s_axi_rdata[IMS_RXNF] == ($past(rx_count_in) >= $past(s_q.rx_thr));
  endproperty
  a_rd_rxnf: assert property (p_rd_rxnf)
    else $error("rx threshold bit wrong");

  property p_rd_rxf;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd ##0 s_q.mask[IMS_RXF] |=>
        s_axi_rdata[IMS_RXF] == ($past(rx_count_in) == FULL_CNT);
  endproperty
  a_rd_rxf: assert property (p_rd_rxf)
    else $error("rx full bit wrong");

  property p_rd_und;
    @(posedge core_clk_in) disable iff (reset_in)
      s_masked_rd ##0 s_q.mask[IMS_SRDUND] |=> s_axi_rdata[IMS_SRDUND] ==
        ($past(slave_read_active_in) && $past(tx_count_in) == '0);
  endproperty
  a_rd_und: assert property (p_rd_und)
    else $error("slave read empty bit wrong");

  // Request pulses set the pending flags; a served pulse alone clears them.
  property p_srd_pend;
    @(posedge core_clk_in) disable iff (reset_in)
      slave_read_req_in |=> s_q.srd_pend;
  endproperty
  a_srd_pend: assert property (p_srd_pend)
    else $error("slave read request not pending");

  property p_srd_served;
    @(posedge core_clk_in) disable iff (reset_in)
      slave_req_served_in && !slave_read_req_in |=> !s_q.srd_pend;
  endproperty
  a_srd_served: assert property (p_srd_served)
    else $error("served slave read still pending");

  property p_swr_pend;
    @(posedge core_clk_in) disable iff (reset_in)
      slave_write_req_in |=> s_q.swr_pend;
  endproperty
  a_swr_pend: assert property (p_swr_pend)
    else $error("slave write request not pending");

  // Event pulses latch their sticky bits at the next edge.
  property p_sdone;
    @(posedge core_clk_in) disable iff (reset_in)
      slave_done_in |=> s_q.sticky[IMS_SDONE];
  endproperty
  a_sdone: assert property (p_sdone)
    else $error("slave done not latched");

  property p_arb;
    @(posedge core_clk_in) disable iff (reset_in)
      arb_lost_in |=> s_q.sticky[IMS_ARBL];
  endproperty
  a_arb: assert property (p_arb)
    else $error("arbitration loss not latched");

  property p_berr;
    @(posedge core_clk_in) disable iff (reset_in)
      bus_error_in |=> s_q.sticky[IMS_BERR];
  endproperty
  a_berr: assert property (p_berr)
    else $error("bus error not latched");

  // Without a clear write no sticky bit ever drops.
  property p_sticky_hold;
    @(posedge core_clk_in) disable iff (reset_in)
      !(wr_go && waddr == IMS_CLEAR_OFS) |=>
        (s_q.sticky & $past(s_q.sticky)) == $past(s_q.sticky);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky bit dropped without a clear");

  // Writing the masked word changes no register behind it.
  property p_wr_ignored;
    @(posedge core_clk_in) disable iff (reset_in)
      wr_go && waddr == IMS_MASKED_OFS |=>
        $stable(s_q.mask) && $stable(s_q.tx_thr) && $stable(s_q.rx_thr);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored)
    else $error("write to masked word changed a register");

  property p_hold_req;
    @(posedge core_clk_in) disable iff (reset_in)
      done_hold |-> !raw[IMS_SWRREQ] && !raw[IMS_SRDREQ];
  endproperty
  a_hold_req: assert property (p_hold_req)
    else $error("slave request shown during done");

  property p_nostop;
    @(posedge core_clk_in) disable iff (reset_in)
      master_done_in && !master_stop_in |=> s_q.sticky[IMS_MDNS]
        ##0 s_q.sticky[IMS_MDONE];
  endproperty
  a_nostop: assert property (p_nostop)
    else $error("no-stop done not latched");
endmodule

// [pkg/ims_pkg.sv]
// Package for the masked interrupt status block of the two-wire controller.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock domain.
package ims_pkg;
  // Register byte offsets.
  localparam logic [7:0] IMS_RAW_OFS = 8'h30;
  localparam logic [7:0] IMS_MASKED_OFS = 8'h34;
  localparam logic [7:0] IMS_CLEAR_OFS = 8'h38;
  localparam logic [7:0] IMS_MASK_OFS = 8'h3c;
  localparam logic [7:0] IMS_TX_THR_OFS = 8'h40;
  localparam logic [7:0] IMS_RX_THR_OFS = 8'h44;
  localparam logic [7:0] IMS_CTRL_OFS = 8'h48;
  // Field positions in the status word.
  localparam int IMS_TXE = 0;
  localparam int IMS_TXNE = 1;
  localparam int IMS_TXF = 2;
  localparam int IMS_TXOVR = 3;
  localparam int IMS_RXE = 4;
  localparam int IMS_RXNF = 5;
  localparam int IMS_RXF = 6;
  localparam int IMS_SRDREQ = 16;
  localparam int IMS_SRDUND = 17;
  localparam int IMS_SWRREQ = 18;
  localparam int IMS_MDONE = 19;
  localparam int IMS_SDONE = 20;
  localparam int IMS_ARBL = 24;
  localparam int IMS_BERR = 25;
  localparam int IMS_MDNS = 28;
  // Implemented bits; everything else reads zero.
  localparam logic [31:0] IMS_IMPL = 32'h131f007f;
  // Sticky bits: cleared only by a one written to the clear register; raw bits 16 to 18 come from the request flags and underrun level.
  localparam logic [31:0] IMS_STICKY = 32'h131f0008;
  localparam logic [31:0] IMS_RESET = 32'h00000000;
  localparam logic [1:0] IMS_OKAY = 2'h0;
  localparam logic [1:0] IMS_SLVERR = 2'h2;
  typedef enum logic [1:0] {IMS_IDLE = 2'h0, IMS_RESP = 2'h1} ims_wst_t;
endpackage
